// File: hdl/cbag_top.sv
// file: circular-buffer address generator with axi4-lite register access
// assumes: cpu pipeline drives one pointer update per cycle, synchronous to clock
//
// Behaviour
// RL1 - buffers may start at any address, up to five buffers with three length settings.
// RL2 - in native circular mode the pointer is an offset added to the buffer base.
// RL3 - a pointer steps circularly if its mode bit is set or the instruction is qualified.
// RL4 - with the legacy flag set native circular addressing is not offered.
// RL5 - legacy-style circular stepping works whatever the legacy flag holds.
// RL6 - pointers 0-3, 4-7 and the coefficient pointer each use their own length register.
// RL7 - after reset every pointer is linear.
// RL8 - the second status register holds one mode bit per pointer, bit n for pointer n; here it has 8 bits for pointers 0-7 and none for the coefficient pointer.
// RL9 - pointer pairs share a base register, each pointer has its own extended register.
// RL10 - the start address is the 7 extended bits above the 16-bit base register.
// RL11 - software writes base and extended registers, then sets the offset to zero.
// RL12 - software loads a start offset as the absolute address minus the base.
// RL13 - base plus offset is readable for recovering an absolute address.
// RL14 - circular steps wrap modulo the buffer length; here a step of the length or more leaves the pointer unchanged.
//
// Added by the designer: the AXI4-Lite register port and the register offsets.
`timescale 1ns/10ps
module cbag_top
  import cbag_pkg::*;
(
  // clock and reset
  input wire logic clock,
  input wire logic sys_rst,
  // axi4-lite write address
  input wire logic [7:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  // axi4-lite write data
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  // axi4-lite write response
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  // axi4-lite read address
  input wire logic [7:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  // axi4-lite read data
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  // pointer update from the pipeline
  input wire logic upd_valid,
  input wire logic [3:0] upd_sel,
  input wire logic [15:0] upd_step,
  input wire logic upd_decrement,
  input wire logic upd_circ_qual,
  input wire logic upd_legacy_circ,
  // generated data address
  output logic [22:0] addr_out,
  output logic addr_valid
);
  import cbag_pkg::*;

  logic [7:0] status2_q;
  logic legacy_compat_flag_q;
  logic [15:0] len_low_q, len_high_q, len_coeff_q;
  logic [15:0] base_q [0:4];
  logic [15:0] ptr_q [0:CBAG_NPTR];
  logic [6:0] ext_q [0:CBAG_NPTR];
  logic [15:0] abs_sel_q;

  // axi write channel state
  logic aw_have_q, w_have_q;
  logic [7:0] aw_addr_q;
  logic [31:0] w_data_q;
  logic [3:0] w_strb_q;
  logic wr_fire;
  assign wr_fire = aw_have_q && w_have_q && !s_axi_bvalid;

  always_ff @(posedge clock or posedge sys_rst) begin
    if (sys_rst) begin
      aw_have_q <= 1'b0;
      w_have_q <= 1'b0;
      aw_addr_q <= 8'h00;
      w_data_q <= 32'h0000_0000;
      w_strb_q <= 4'h0;
      s_axi_awready <= 1'b0;
      s_axi_wready <= 1'b0;
      s_axi_bvalid <= 1'b0;
      s_axi_bresp <= CBAG_RESP_OKAY;
    end else begin
      // ready toggles while idle; a capture holds it low until the write completes
      s_axi_awready <= !aw_have_q && !s_axi_awready && !(s_axi_awvalid && s_axi_awready);
      s_axi_wready <= !w_have_q && !s_axi_wready && !(s_axi_wvalid && s_axi_wready);
      if (s_axi_awvalid && s_axi_awready) begin
        aw_have_q <= 1'b1;
        aw_addr_q <= s_axi_awaddr;
        s_axi_awready <= 1'b0;
      end
      if (s_axi_wvalid && s_axi_wready) begin
        w_have_q <= 1'b1;
        w_data_q <= s_axi_wdata;
        w_strb_q <= s_axi_wstrb;
        s_axi_wready <= 1'b0;
      end
      if (wr_fire) begin
        aw_have_q <= 1'b0;
        w_have_q <= 1'b0;
        s_axi_bvalid <= 1'b1;
        s_axi_bresp <= wr_hit(aw_addr_q) ? CBAG_RESP_OKAY : CBAG_RESP_SLVERR;
      end else if (s_axi_bvalid && s_axi_bready) begin
        s_axi_bvalid <= 1'b0;
      end
    end
  end

  function automatic logic wr_hit(input logic [7:0] a);
    wr_hit = (a[1:0] == 2'b00) && (a <= CBAG_OFS_ABS);
  endfunction

  function automatic logic [15:0] merge16(input logic [15:0] old, input logic [31:0] d,
                                          input logic [3:0] s);
    merge16 = {s[1] ? d[15:8] : old[15:8], s[0] ? d[7:0] : old[7:0]};
  endfunction

  // length register for a pointer index
  function automatic logic [15:0] len_of(input logic [3:0] sel);
    if (sel == CBAG_SEL_COEFF) begin
      len_of = len_coeff_q; // RL6
    end else if (sel[2]) begin
      len_of = len_high_q; // RL6
    end else begin
      len_of = len_low_q; // RL6
    end
  endfunction

  // base register index: pairs share, coefficient has its own
  function automatic logic [2:0] base_idx(input logic [3:0] sel);
    base_idx = (sel == CBAG_SEL_COEFF) ? 3'd4 : {1'b0, sel[2:1]}; // RL9
  endfunction

  // update decode
  logic upd_ok;
  logic upd_circ;
  logic [15:0] upd_next;
  logic [15:0] upd_cur;
  logic [15:0] upd_len;
  assign upd_ok = upd_valid && (upd_sel <= CBAG_SEL_COEFF);
  assign upd_cur = upd_ok ? ptr_q[upd_sel] : 16'h0000;
  assign upd_len = len_of(upd_sel);
  always_comb begin
    upd_circ = 1'b0;
    if (upd_ok && upd_legacy_circ) begin
      upd_circ = 1'b1; // RL5
    end else if (upd_ok && !legacy_compat_flag_q) begin // RL4
      upd_circ = upd_circ_qual || ((upd_sel != CBAG_SEL_COEFF) && status2_q[upd_sel[2:0]]); // RL3
    end
  end

  cbag_step u_step (
    .offset(upd_cur),
    .step(upd_step),
    .length(upd_len),
    .decrement(upd_decrement),
    .circular(upd_circ),
    .next_offset(upd_next)
  );

  // control registers
  always_ff @(posedge clock or posedge sys_rst) begin
    if (sys_rst) begin
      status2_q <= CBAG_STATUS2_RST; // RL7
      legacy_compat_flag_q <= CBAG_LEGACY_RST;
      len_low_q <= 16'h0000;
      len_high_q <= 16'h0000;
      len_coeff_q <= 16'h0000;
      abs_sel_q <= 16'h0000;
    end else if (wr_fire) begin
      case (aw_addr_q)
        CBAG_OFS_STATUS2: if (w_strb_q[0]) status2_q <= w_data_q[7:0]; // RL8
        CBAG_OFS_CTRL: begin
          if (w_strb_q[0]) legacy_compat_flag_q <= w_data_q[CBAG_CTRL_LEGACY_BIT];
          abs_sel_q <= merge16(abs_sel_q, {w_data_q[31:16], w_data_q[31:16]},
                               {2'b00, w_strb_q[3:2]});
        end
        CBAG_OFS_LEN_LOW: len_low_q <= merge16(len_low_q, w_data_q, w_strb_q); // RL1
        CBAG_OFS_LEN_HIGH: len_high_q <= merge16(len_high_q, w_data_q, w_strb_q);
        CBAG_OFS_LEN_COEFF: len_coeff_q <= merge16(len_coeff_q, w_data_q, w_strb_q);
        default: begin
        end
      endcase
    end
  end

  // base registers, five of them, no alignment imposed
  genvar gb;
  generate
    for (gb = 0; gb < 5; gb++) begin : g_base
      always_ff @(posedge clock or posedge sys_rst) begin
        if (sys_rst) begin
          base_q[gb] <= 16'h0000;
        end else if (wr_fire && aw_addr_q == CBAG_OFS_BASE0 + 8'(4 * gb)) begin
          base_q[gb] <= merge16(base_q[gb], w_data_q, w_strb_q); // RL1
        end
      end
    end
  endgenerate

  // pointers and their extended bits; software write wins over an update
  genvar gp;
  generate
    for (gp = 0; gp <= CBAG_NPTR; gp++) begin : g_ptr
      always_ff @(posedge clock or posedge sys_rst) begin
        if (sys_rst) begin
          ptr_q[gp] <= 16'h0000;
          ext_q[gp] <= 7'h00;
        end else begin
          // a software write to the pointer wins over a same-cycle update
          if (wr_fire && aw_addr_q == CBAG_OFS_PTR0 + 8'(4 * gp)) begin
            ptr_q[gp] <= merge16(ptr_q[gp], w_data_q, w_strb_q);
          end else if (upd_ok && upd_sel == 4'(gp)) begin
            ptr_q[gp] <= upd_next; // RL14
          end
          // an extended-bit write must not swallow a pointer update
          if (wr_fire && aw_addr_q == CBAG_OFS_EXT0 + 8'(4 * gp) && w_strb_q[0]) begin
            ext_q[gp] <= w_data_q[6:0]; // RL9
          end
        end
      end
    end
  endgenerate

  // effective address: offset plus base when native circular, else page and pointer
  logic [22:0] start_addr;
  assign start_addr = {ext_q[upd_ok ? upd_sel : 4'h0], base_q[base_idx(upd_sel)]}; // RL10
  always_ff @(posedge clock or posedge sys_rst) begin
    if (sys_rst) begin
      addr_out <= 23'h00_0000;
      addr_valid <= 1'b0;
    end else begin
      addr_valid <= upd_ok;
      if (upd_ok && upd_circ && !upd_legacy_circ) begin
        addr_out <= 23'(start_addr + 23'(upd_cur)); // RL2
      end else begin
        addr_out <= {ext_q[upd_ok ? upd_sel : 4'h0], upd_cur};
      end
    end
  end

  // read channel
  logic [31:0] rd_val;
  logic rd_hit;
  logic [3:0] abs_p;
  assign abs_p = (abs_sel_q[3:0] <= CBAG_SEL_COEFF) ? abs_sel_q[3:0] : 4'h0;
  always_comb begin
    rd_val = 32'h0000_0000;
    rd_hit = 1'b1;
    if (s_axi_araddr == CBAG_OFS_STATUS2) begin
      rd_val = {24'h00_0000, status2_q};
    end else if (s_axi_araddr == CBAG_OFS_CTRL) begin
      rd_val = {abs_sel_q, 15'h0000, legacy_compat_flag_q};
    end else if (s_axi_araddr == CBAG_OFS_LEN_LOW) begin
      rd_val = {16'h0000, len_low_q};
    end else if (s_axi_araddr == CBAG_OFS_LEN_HIGH) begin
      rd_val = {16'h0000, len_high_q};
    end else if (s_axi_araddr == CBAG_OFS_LEN_COEFF) begin
      rd_val = {16'h0000, len_coeff_q};
    end else if (s_axi_araddr >= CBAG_OFS_BASE0 && s_axi_araddr <= CBAG_OFS_BASE_COEFF
                 && s_axi_araddr[1:0] == 2'b00) begin
      rd_val = {16'h0000, base_q[3'(8'(s_axi_araddr - CBAG_OFS_BASE0) >> 2)]};
    end else if (s_axi_araddr >= CBAG_OFS_PTR0 && s_axi_araddr <= CBAG_OFS_PTR_COEFF
                 && s_axi_araddr[1:0] == 2'b00) begin
      rd_val = {16'h0000, ptr_q[4'(8'(s_axi_araddr - CBAG_OFS_PTR0) >> 2)]};
    end else if (s_axi_araddr >= CBAG_OFS_EXT0 && s_axi_araddr <= CBAG_OFS_EXT_COEFF
                 && s_axi_araddr[1:0] == 2'b00) begin
      rd_val = {25'h000_0000, ext_q[4'(8'(s_axi_araddr - CBAG_OFS_EXT0) >> 2)]};
    end else if (s_axi_araddr == CBAG_OFS_ABS) begin
      // ext bits above base plus offset of the selected pointer
      rd_val = {9'h000, 23'({ext_q[abs_p], base_q[base_idx(abs_p)]}
                            + 23'(ptr_q[abs_p]))}; // RL13
    end else begin
      rd_hit = 1'b0;
    end
  end

  always_ff @(posedge clock or posedge sys_rst) begin
    if (sys_rst) begin
      s_axi_arready <= 1'b0;
      s_axi_rvalid <= 1'b0;
      s_axi_rdata <= 32'h0000_0000;
      s_axi_rresp <= CBAG_RESP_OKAY;
    end else begin
      s_axi_arready <= 1'b0;
      if (s_axi_arvalid && !s_axi_arready && !s_axi_rvalid) begin
        s_axi_arready <= 1'b1;
        s_axi_rvalid <= 1'b1;
        s_axi_rdata <= rd_val;
        s_axi_rresp <= rd_hit ? CBAG_RESP_OKAY : CBAG_RESP_SLVERR;
      end else if (s_axi_rvalid && s_axi_rready) begin
        s_axi_rvalid <= 1'b0;
      end
    end
  end
endmodule

// File: hdl/cbag_pkg.sv
// package: constants for the circular-buffer address generator
// assumes: register map reached over axi4-lite, 32-bit data, word-aligned offsets
package cbag_pkg;
  localparam int CBAG_NPTR = 8;
  localparam int CBAG_OFS_W = 16;
  localparam int CBAG_PAGE_W = 7;
  localparam int CBAG_ADDR_W = 23;
  // register byte offsets
  localparam logic [7:0] CBAG_OFS_STATUS2 = 8'h00;
  localparam logic [7:0] CBAG_OFS_CTRL = 8'h04;
  localparam logic [7:0] CBAG_OFS_LEN_LOW = 8'h08;
  localparam logic [7:0] CBAG_OFS_LEN_HIGH = 8'h0c;
  localparam logic [7:0] CBAG_OFS_LEN_COEFF = 8'h10;
  localparam logic [7:0] CBAG_OFS_BASE0 = 8'h14;
  localparam logic [7:0] CBAG_OFS_BASE_COEFF = 8'h24;
  localparam logic [7:0] CBAG_OFS_PTR0 = 8'h28;
  localparam logic [7:0] CBAG_OFS_PTR_COEFF = 8'h48;
  localparam logic [7:0] CBAG_OFS_EXT0 = 8'h4c;
  localparam logic [7:0] CBAG_OFS_EXT_COEFF = 8'h6c;
  localparam logic [7:0] CBAG_OFS_ABS = 8'h70;
  // field positions and reset values
  localparam int CBAG_CTRL_LEGACY_BIT = 0;
  localparam logic [7:0] CBAG_STATUS2_RST = 8'h00;
  localparam logic CBAG_LEGACY_RST = 1'b0;
  localparam logic [1:0] CBAG_RESP_OKAY = 2'b00;
  localparam logic [1:0] CBAG_RESP_SLVERR = 2'b10;
  // pointer index of the coefficient pointer on the update port
  localparam logic [3:0] CBAG_SEL_COEFF = 4'h8;
endpackage

// File: hdl/cbag_step.sv
// file: next-offset computation for one pointer update
// assumes: length of zero or one leaves a circular pointer at zero
`timescale 1ns/10ps
module cbag_step (
  // operands
  input wire logic [15:0] offset,
  input wire logic [15:0] step,
  input wire logic [15:0] length,
  input wire logic decrement,
  input wire logic circular,
  // result
  output logic [15:0] next_offset
);
  logic [16:0] up;
  logic [16:0] dn;
  logic [15:0] st;
  always_comb begin
    st = (step >= length) ? 16'h0000 : step;
    up = 17'(offset) + 17'(st);
    dn = 17'(offset) - 17'(st);
    if (!circular) begin
      next_offset = decrement ? dn[15:0] : up[15:0];
    end else if (length <= 16'h0001) begin
      next_offset = 16'h0000;
    end else if (decrement) begin
      // below zero wraps to the top of the buffer
      next_offset = dn[16] ? 16'(dn + 17'(length)) : dn[15:0]; // RL14
    end else begin
      // past the last element wraps back from zero
      next_offset = (up >= 17'(length)) ? 16'(up - 17'(length)) : up[15:0]; // RL14
    end
  end
endmodule

// File: tb/cbag_properties.sv
// holds: port-level properties of the address generator
// assumes: bound to cbag_top, one clock domain
`timescale 1ns/10ps
module cbag_properties (
  // clock and reset
  input wire logic clock,
  input wire logic sys_rst,
  // register bus
  input wire logic s_axi_awvalid,
  input wire logic s_axi_awready,
  input wire logic s_axi_wvalid,
  input wire logic s_axi_wready,
  input wire logic [1:0] s_axi_bresp,
  input wire logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic s_axi_arvalid,
  input wire logic s_axi_arready,
  input wire logic [31:0] s_axi_rdata,
  input wire logic s_axi_rvalid,
  input wire logic s_axi_rready,
  // pointer update
  input wire logic upd_valid,
  input wire logic [3:0] upd_sel,
  input wire logic addr_valid
);
  default clocking @(posedge clock); endclocking
  default disable iff (sys_rst);
  sequence s_upd;
    upd_valid && upd_sel <= 4'h8;
  endsequence
  sequence s_aw_taken;
    s_axi_awvalid && s_axi_awready;
  endsequence
  AST_UPD_ADDR: assert property (s_upd |=> addr_valid)
    else $error("update gave no address");
  AST_NO_UPD: assert property (!upd_valid |=> !addr_valid)
    else $error("address without update");
  AST_B_HOLD: assert property (s_axi_bvalid && !s_axi_bready |=>
    s_axi_bvalid && $stable(s_axi_bresp))
    else $error("write response dropped");
  AST_B_ANSWER: assert property (s_aw_taken |-> ##[1:2] s_axi_bvalid)
    else $error("write response missing");
  AST_AW_ONCE: assert property (s_aw_taken |=> !s_axi_awready)
    else $error("write address taken twice");
  AST_W_PAIR: assert property (s_axi_wvalid && s_axi_wready |-> s_axi_awready)
    else $error("data taken apart from address");
  AST_R_ANSWER: assert property (s_axi_arvalid && s_axi_arready |-> s_axi_rvalid)
    else $error("read data missing");
  AST_R_HOLD: assert property (s_axi_rvalid && !s_axi_rready |=>
    s_axi_rvalid && $stable(s_axi_rdata))
    else $error("read data dropped");
endmodule

// File: tb/cbag_pipe_model.sv
// holds: cpu pipeline model issuing pointer updates
// assumes: one update at a time, lines inverted while idle
`timescale 1ns/10ps
module cbag_pipe_model (
  // clock
  input wire logic clock,
  // update request
  output logic upd_valid,
  output logic [3:0] upd_sel,
  output logic [15:0] upd_step,
  output logic upd_decrement,
  output logic upd_circ_qual,
  output logic upd_legacy_circ
);
  initial begin
    upd_valid = 1'b0;
    {upd_sel, upd_step, upd_decrement, upd_circ_qual, upd_legacy_circ} = '0;
  end
  task issue(input logic [3:0] s, input logic [15:0] st, input logic dc, q, l);
    @(posedge clock);
    upd_valid <= 1'b1;
    {upd_sel, upd_step, upd_decrement, upd_circ_qual, upd_legacy_circ} <= {s, st, dc, q, l};
    @(posedge clock);
    upd_valid <= 1'b0;
    {upd_sel, upd_step, upd_decrement, upd_circ_qual, upd_legacy_circ} <= ~{s, st, dc, q, l};
  endtask
endmodule

// File: tb/circular_buffer_address_gen_test.sv
// holds: self-checking bench of the address generator
// assumes: cbag_pkg, cbag_top, pipeline model and properties compiled first
`timescale 1ns/10ps
module circular_buffer_address_gen_test;
  import cbag_pkg::*;
  logic clock = 1'b0;
  logic sys_rst = 1'b1;
  logic [7:0] s_axi_awaddr = 8'h00;
  logic [7:0] s_axi_araddr = 8'h00;
  logic [31:0] s_axi_wdata = 32'h0;
  logic [3:0] s_axi_wstrb = 4'h0;
  logic s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0;
  logic s_axi_arvalid = 1'b0, s_axi_rready = 1'b0;
  logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid, addr_valid;
  logic [1:0] s_axi_bresp, s_axi_rresp, r;
  logic [31:0] s_axi_rdata, d;
  logic [22:0] addr_out;
  logic upd_valid, upd_decrement, upd_circ_qual, upd_legacy_circ;
  logic [3:0] upd_sel;
  logic [15:0] upd_step;
  int error_cnt = 0, checked = 0, cycles = 0, ofs, len, st, dc;
  always #5 clock = ~clock;
  cbag_top dut (.clock, .sys_rst, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready,
    .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid,
    .s_axi_bready, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata,
    .s_axi_rresp, .s_axi_rvalid, .s_axi_rready, .upd_valid, .upd_sel, .upd_step,
    .upd_decrement, .upd_circ_qual, .upd_legacy_circ, .addr_out, .addr_valid);
  cbag_pipe_model pipe (.clock, .upd_valid, .upd_sel, .upd_step, .upd_decrement,
    .upd_circ_qual, .upd_legacy_circ);
  task results;
    $display("checks %0d errors %0d", checked, error_cnt);
    if (error_cnt == 0 && checked > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  endtask
  always @(posedge clock) begin
    cycles++;
    if (cycles == 20000) begin
      error_cnt++;
      results();
    end
  end
  task chk(input string n, input logic [31:0] seen, exp);
    checked++;
    if (seen !== exp) begin
      $display("wrong value %s expected %h seen %h", n, exp, seen);
      error_cnt++;
    end
  endtask
  task wr(input logic [7:0] a, input logic [31:0] v, input int late = 0);
    logic aw, w;
    aw = 1'b1;
    w = 1'b1;
    @(posedge clock);
    {s_axi_awaddr, s_axi_wdata, s_axi_wstrb} <= {a, v, 4'hf};
    {s_axi_awvalid, s_axi_wvalid, s_axi_bready} <= {2'b11, late == 0};
    while (aw || w) begin
      @(posedge clock);
      if (s_axi_awready) aw = 1'b0;
      if (s_axi_wready) w = 1'b0;
      s_axi_awvalid <= aw;
      s_axi_wvalid <= w;
    end
    if (late > 0) begin
      repeat (late) @(posedge clock);
      s_axi_bready <= 1'b1;
      @(posedge clock);
    end
    while (!s_axi_bvalid) @(posedge clock);
    r = s_axi_bresp;
    s_axi_bready <= 1'b0;
  endtask
  task rd(input logic [7:0] a, input int late = 0);
    @(posedge clock);
    s_axi_araddr <= a;
    {s_axi_arvalid, s_axi_rready} <= {1'b1, late == 0};
    do @(posedge clock); while (!s_axi_arready);
    s_axi_arvalid <= 1'b0;
    if (late > 0) begin
      repeat (late) @(posedge clock);
      s_axi_rready <= 1'b1;
      @(posedge clock);
    end
    while (!s_axi_rvalid) @(posedge clock);
    d = s_axi_rdata;
    r = s_axi_rresp;
    s_axi_rready <= 1'b0;
  endtask
  task upd(input int s, stp, de, q, l, e);
    pipe.issue(4'(s), 16'(stp), 1'(de), 1'(q), 1'(l));
    #1;
    chk("update", {8'h0, addr_valid, addr_out}, {8'h0, 1'b1, 23'(e)});
  endtask
  function automatic int nxt(int o, s, l, de);
    if (de) return (o - s + l) % l;
    return (o + s) % l;
  endfunction
  initial begin
    ofs = $urandom(24);
    repeat (4) @(posedge clock);
    sys_rst <= 1'b0;
    rd(CBAG_OFS_STATUS2);
    chk("status2", d, 32'h0);
    rd(CBAG_OFS_CTRL);
    chk("ctrl", d, 32'h0);
    wr(CBAG_OFS_LEN_LOW, 32'h4);
    wr(CBAG_OFS_BASE0, 32'h1234);
    wr(CBAG_OFS_EXT0 + 8'h04, 32'h05);
    wr(CBAG_OFS_PTR0 + 8'h04, 32'h0);
    wr(CBAG_OFS_STATUS2, 32'h2, 2);
    chk("bresp", r, CBAG_RESP_OKAY);
    rd(CBAG_OFS_STATUS2, 2);
    chk("status2", d, 32'h2);
    for (int i = 0; i < 5; i++) upd(1, 1, 0, 0, 0, 23'h051234 + i % 4);
    upd(1, 1, 1, 0, 0, 23'h051235);
    upd(1, 1, 1, 0, 0, 23'h051234);
    upd(1, 1, 1, 0, 0, 23'h051237);
    wr(CBAG_OFS_EXT0, 32'h01);
    wr(CBAG_OFS_PTR0, 32'h3);
    upd(0, 1, 0, 1, 0, 23'h011237);
    upd(0, 1, 0, 1, 0, 23'h011234);
    wr(CBAG_OFS_EXT0 + 8'h0c, 32'h02);
    wr(CBAG_OFS_PTR0 + 8'h0c, 32'h00fe);
    upd(3, 1, 0, 0, 0, 23'h0200fe);
    upd(3, 1, 0, 0, 0, 23'h0200ff);
    wr(CBAG_OFS_LEN_HIGH, 32'h3);
    wr(CBAG_OFS_BASE0 + 8'h08, 32'h0100);
    wr(CBAG_OFS_PTR0 + 8'h10, 32'h2);
    upd(4, 1, 0, 1, 0, 23'h000102);
    upd(4, 1, 0, 1, 0, 23'h000100);
    wr(CBAG_OFS_LEN_COEFF, 32'h2);
    wr(CBAG_OFS_BASE_COEFF, 32'h0200);
    wr(CBAG_OFS_PTR_COEFF, 32'h1);
    upd(CBAG_SEL_COEFF, 1, 0, 1, 0, 23'h000201);
    upd(CBAG_SEL_COEFF, 1, 0, 1, 0, 23'h000200);
    wr(CBAG_OFS_CTRL, 32'h1);
    wr(CBAG_OFS_PTR0 + 8'h04, 32'h2);
    upd(1, 1, 0, 1, 0, 23'h050002);
    upd(1, 1, 0, 0, 0, 23'h050003);
    upd(1, 1, 0, 0, 0, 23'h050004);
    for (int f = 1; f >= 0; f--) begin
      wr(CBAG_OFS_CTRL, f);
      wr(CBAG_OFS_PTR0 + 8'h0c, 32'h1);
      upd(3, 2, 0, 0, 1, 23'h020001);
      upd(3, 2, 0, 0, 1, 23'h020003);
      upd(3, 3, 1, 0, 1, 23'h020001);
    end
    wr(CBAG_OFS_CTRL, 32'h0001_0000);
    wr(CBAG_OFS_PTR0 + 8'h04, 32'h2);
    rd(CBAG_OFS_ABS);
    chk("abs", d, 32'h051236);
    rd(8'h74);
    chk("rresp", r, CBAG_RESP_SLVERR);
    wr(8'h02, 32'h0);
    chk("bresp", r, CBAG_RESP_SLVERR);
    len = 2 + $urandom % 14;
    ofs = $urandom % len;
    wr(CBAG_OFS_LEN_LOW, len);
    wr(CBAG_OFS_PTR0 + 8'h04, ofs);
    repeat (30) begin
      st = $urandom % len;
      dc = $urandom % 2;
      upd(1, st, dc, 0, 0, 23'h051234 + ofs);
      ofs = nxt(ofs, st, len, dc);
    end
    // selectors above the coefficient pointer are ignored
    pipe.issue(4'h9, 16'h0001, 1'b0, 1'b0, 1'b0);
    #1;
    chk("ignored sel", {31'h0, addr_valid}, 32'h0);
    // reset in mid-run returns every pointer to linear and zero
    @(posedge clock);
    sys_rst <= 1'b1;
    repeat (2) @(posedge clock);
    sys_rst <= 1'b0;
    rd(CBAG_OFS_STATUS2);
    chk("status2 after reset", d, 32'h0);
    rd(CBAG_OFS_PTR0 + 8'h04);
    chk("ptr after reset", d, 32'h0);
    results();
  end
endmodule
bind cbag_top cbag_properties u_props (.clock, .sys_rst, .s_axi_awvalid, .s_axi_awready,
  .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready,
  .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rvalid, .s_axi_rready,
  .upd_valid, .upd_sel, .addr_valid);
